/* design/ldiod_top.sv */
// Purpose: Host I/O decode and activation of the logical units
// Assumes: Host cycle strobes come from logic on i_sys_clk
// Notes: Selects and forwarded cycle appear one cycle after the strobe
`timescale 1ns/100ps
`default_nettype none
`include "ldiod_params.svh"
module ldiod_top (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  // Strap pin
  input wire logic i_config_port_strap,
  // Host I/O cycle
  input wire logic [15:0] i_io_addr,
  input wire logic [7:0] i_io_wdata,
  input wire logic i_io_rd,
  input wire logic i_io_wr,
  // Config port read answer
  output logic [7:0] o_cfg_rdata,
  output logic o_cfg_rvalid,
  // Unit selects
  output logic o_sel_floppy,
  output logic o_sel_parallel,
  output logic o_sel_serial1,
  output logic o_sel_serial2,
  output logic o_sel_keyboard,
  output logic o_sel_game,
  output logic o_sel_midi,
  // Forwarded cycle
  output logic [15:0] o_unit_addr,
  output logic [7:0] o_unit_wdata,
  output logic o_unit_rd,
  output logic o_unit_wr,
  // Unit state
  output logic [15:0] o_unit_on,
  output ldiod_pkg::ldiod_unit_t o_cur_unit
);
  import ldiod_pkg::*;

  localparam logic [15:0] ACT_MASK = `LDIOD_ACT_MASK;
  localparam logic [15:0] BASE_MASK = `LDIOD_BASE_MASK;
  localparam logic [15:0] IRQ_MASK = `LDIOD_IRQ_MASK;
  localparam logic [15:0] DMA_MASK = `LDIOD_DMA_MASK;

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic strap_meta_reg;
  logic strap_sync_reg;
  ldiod_init_t init_state_reg;
  logic [15:0] strap_base_reg;
  logic [7:0] index_reg;
  ldiod_unit_t unit_num_reg;
  logic [7:0] osc_reg;
  logic [7:0] cfgb_lo_reg;
  logic [7:0] cfgb_hi_reg;
  logic cfg_reloc_reg;
  logic [15:0] unit_on_reg;
  logic [15:0] unit_on_next;
  logic [7:0] base_hi_reg [16];
  logic [7:0] base_lo_reg [16];
  logic [3:0] irq_reg [16];
  logic [2:0] dma_reg [16];

  // ----------------------------------------
  // Config port decode
  // ----------------------------------------
  logic qual16;
  logic [15:0] cfg_stored;
  logic cfg_stored_ok;
  logic [15:0] cfg_port;
  logic [15:0] cfg_port_data;
  logic cfg_hit_idx;
  logic cfg_hit_data;
  logic cfg_wr_data;
  logic [3:0] cur;
  logic cur_ok;
  logic act_ok;
  logic base_ok;
  logic irq_ok;
  logic dma_ok;
  logic wr_act;
  logic wr_pwr;
  logic [15:0] act_vec;
  logic [7:0] rd_value;
  logic cyc;

  // RL12 upper address qualifier
  assign qual16 = osc_reg[`LDIOD_OSC_QUAL_BIT];
  assign cfg_stored = {cfgb_hi_reg, cfgb_lo_reg};
  // RL10 relocation only to a legal even address
  assign cfg_stored_ok = (cfg_stored >= `LDIOD_CFG_LO) && (cfg_stored <= `LDIOD_CFG_HI) &&
                         !cfg_stored[0];
  // RL13 strap position until relocated
  assign cfg_port = (cfg_reloc_reg && cfg_stored_ok) ? cfg_stored : strap_base_reg;
  assign cfg_port_data = cfg_port + 16'h0001;
  // RL10 index at the port, data at port plus one
  assign cfg_hit_idx = (i_io_addr[11:0] == cfg_port[11:0]) &&
                       (!qual16 || (i_io_addr[15:12] == cfg_port[15:12]));
  assign cfg_hit_data = (i_io_addr[11:0] == cfg_port_data[11:0]) &&
                        (!qual16 || (i_io_addr[15:12] == cfg_port_data[15:12]));
  assign cfg_wr_data = i_io_wr && cfg_hit_data;
  assign cur = unit_num_reg[3:0];
  assign cur_ok = (unit_num_reg[7:4] == 4'h0);
  // RL17 reserved units hold no bits
  assign act_ok = cur_ok && ACT_MASK[cur];
  assign base_ok = cur_ok && BASE_MASK[cur];
  assign irq_ok = cur_ok && IRQ_MASK[cur];
  assign dma_ok = cur_ok && DMA_MASK[cur];
  assign wr_act = cfg_wr_data && (index_reg == `LDIOD_IDX_ACT) && act_ok;
  assign wr_pwr = cfg_wr_data && (index_reg == `LDIOD_IDX_PWR);
  assign act_vec = 16'h0001 << cur;
  // RL2 one stored bit serves both the activate and the power view
  // RL15 bit 0 of the activate index drives the chosen unit
  assign unit_on_next = wr_act ? ((unit_on_reg & ~act_vec) | (i_io_wdata[0] ? act_vec : 16'h0000)) :
                        wr_pwr ? {unit_on_reg[15:8], i_io_wdata & ACT_MASK[7:0]} :
                        unit_on_reg;
  // RL14 unused base registers read zero
  assign rd_value = (index_reg == `LDIOD_IDX_UNIT) ? unit_num_reg :
                    (index_reg == `LDIOD_IDX_PWR) ? (unit_on_reg[7:0] & ACT_MASK[7:0]) :
                    (index_reg == `LDIOD_IDX_OSC) ? osc_reg :
                    (index_reg == `LDIOD_IDX_CFG_LO) ? cfgb_lo_reg :
                    (index_reg == `LDIOD_IDX_CFG_HI) ? cfgb_hi_reg :
                    (index_reg == `LDIOD_IDX_ACT) ? {7'h00, act_ok && unit_on_reg[cur]} :
                    (index_reg == `LDIOD_IDX_BASE_HI && base_ok) ? base_hi_reg[cur] :
                    (index_reg == `LDIOD_IDX_BASE_LO && base_ok) ? base_lo_reg[cur] :
                    (index_reg == `LDIOD_IDX_IRQ && irq_ok) ? {4'h0, irq_reg[cur]} :
                    (index_reg == `LDIOD_IDX_DMA && dma_ok) ? {5'h00, dma_reg[cur]} :
                    8'h00;
  assign cyc = i_io_rd || i_io_wr;

  // ----------------------------------------
  // Unit windows
  // ----------------------------------------
  logic [15:0] base_fdc;
  logic [15:0] base_pp;
  logic [15:0] base_sp1;
  logic [15:0] base_sp2;
  logic [15:0] base_game;
  logic [15:0] base_midi;
  logic fdc_valid, fdc_hit, pp_valid, pp_hit, epp_hit, ecp_hit, sp1_valid, sp1_hit;
  logic sp2_hit, game_hit, midi_hit, kbd_data_hit, kbd_cmd_hit, pp_sel;
  logic [11:0] pp_off;

  assign base_fdc = {base_hi_reg[0], base_lo_reg[0]};
  assign base_pp = {base_hi_reg[3], base_lo_reg[3]};
  assign base_sp1 = {base_hi_reg[4], base_lo_reg[4]};
  assign base_sp2 = {base_hi_reg[5], base_lo_reg[5]};
  assign base_game = {base_hi_reg[9], base_lo_reg[9]};
  assign base_midi = {base_hi_reg[11], base_lo_reg[11]};

  // RL6 eight-byte windows on eight-byte bases
  ldiod_window #(.P_LO(`LDIOD_W8_LO), .P_HI(`LDIOD_W8_HI), .P_ALIGN(16'h0007),
    .P_WIN(16'h0007), .P_OFS(16'h0000)) u_fdc (.i_base(base_fdc), .i_on(unit_on_reg[0]),
    .i_qual16(qual16), .i_addr(i_io_addr), .o_valid(fdc_valid), .o_hit(fdc_hit));
  ldiod_window #(.P_LO(`LDIOD_W8_LO), .P_HI(`LDIOD_W8_HI), .P_ALIGN(16'h0007),
    .P_WIN(16'h0007), .P_OFS(16'h0000)) u_sp1 (.i_base(base_sp1), .i_on(unit_on_reg[4]),
    .i_qual16(qual16), .i_addr(i_io_addr), .o_valid(sp1_valid), .o_hit(sp1_hit));
  ldiod_window #(.P_LO(`LDIOD_W8_LO), .P_HI(`LDIOD_W8_HI), .P_ALIGN(16'h0007),
    .P_WIN(16'h0007), .P_OFS(16'h0000)) u_sp2 (.i_base(base_sp2), .i_on(unit_on_reg[5]),
    .i_qual16(qual16), .i_addr(i_io_addr), .o_valid(), .o_hit(sp2_hit));
  // RL7 four-byte base, enhanced offsets only on eight-byte base
  ldiod_window #(.P_LO(`LDIOD_W8_LO), .P_HI(`LDIOD_PP_HI), .P_ALIGN(16'h0003),
    .P_WIN(16'h0003), .P_OFS(16'h0000)) u_pp (.i_base(base_pp), .i_on(unit_on_reg[3]),
    .i_qual16(qual16), .i_addr(i_io_addr), .o_valid(pp_valid), .o_hit(pp_hit));
  ldiod_window #(.P_LO(`LDIOD_W8_LO), .P_HI(`LDIOD_W8_HI), .P_ALIGN(16'h0007),
    .P_WIN(16'h0007), .P_OFS(16'h0000)) u_epp (.i_base(base_pp), .i_on(unit_on_reg[3]),
    .i_qual16(qual16), .i_addr(i_io_addr), .o_valid(), .o_hit(epp_hit));
  ldiod_window #(.P_LO(`LDIOD_W8_LO), .P_HI(`LDIOD_PP_HI), .P_ALIGN(16'h0003),
    .P_WIN(16'h0003), .P_OFS(`LDIOD_ECP_OFS)) u_ecp (.i_base(base_pp), .i_on(unit_on_reg[3]),
    .i_qual16(qual16), .i_addr(i_io_addr), .o_valid(), .o_hit(ecp_hit));
  // RL9 single register at any byte base; MIDI decodes two registers at an even base
  ldiod_window #(.P_LO(`LDIOD_W8_LO), .P_HI(`LDIOD_GAME_HI), .P_ALIGN(16'h0000),
    .P_WIN(16'h0000), .P_OFS(16'h0000)) u_game (.i_base(base_game), .i_on(unit_on_reg[9]),
    .i_qual16(qual16), .i_addr(i_io_addr), .o_valid(), .o_hit(game_hit));
  ldiod_window #(.P_LO(`LDIOD_W8_LO), .P_HI(`LDIOD_MIDI_HI), .P_ALIGN(16'h0001),
    .P_WIN(16'h0001), .P_OFS(16'h0000)) u_midi (.i_base(base_midi), .i_on(unit_on_reg[11]),
    .i_qual16(qual16), .i_addr(i_io_addr), .o_valid(), .o_hit(midi_hit));
  // RL8 fixed keyboard addresses, not relocatable
  ldiod_window #(.P_LO(`LDIOD_KBD_DATA), .P_HI(`LDIOD_KBD_DATA), .P_ALIGN(16'h0000),
    .P_WIN(16'h0000), .P_OFS(16'h0000)) u_kbd_data (.i_base(`LDIOD_KBD_DATA),
    .i_on(unit_on_reg[7]), .i_qual16(qual16), .i_addr(i_io_addr), .o_valid(),
    .o_hit(kbd_data_hit));
  ldiod_window #(.P_LO(`LDIOD_KBD_CMD), .P_HI(`LDIOD_KBD_CMD), .P_ALIGN(16'h0000),
    .P_WIN(16'h0000), .P_OFS(16'h0000)) u_kbd_cmd (.i_base(`LDIOD_KBD_CMD),
    .i_on(unit_on_reg[7]), .i_qual16(qual16), .i_addr(i_io_addr), .o_valid(),
    .o_hit(kbd_cmd_hit));

  // RL7 offset +3 only via the enhanced path, extended block stops at +402h
  assign pp_sel = (pp_hit && (i_io_addr[1:0] != 2'b11)) || epp_hit ||
                  (ecp_hit && (i_io_addr[1:0] != 2'b11));
  assign pp_off = i_io_addr[11:0] - base_pp[11:0];
  // RL11 hub and RL17 reserved units have no window at all

  // ----------------------------------------
  // Strap capture after reset release
  // ----------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      strap_meta_reg <= 1'b0;
      strap_sync_reg <= 1'b0;
    end else begin
      strap_meta_reg <= i_config_port_strap;
      strap_sync_reg <= strap_meta_reg;
    end
  end

  // RL13 port position taken from the synchronised strap
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      init_state_reg <= LDIOD_WAIT_META;
      strap_base_reg <= `LDIOD_CFG_STRAP_LOW;
    end else begin
      unique case (init_state_reg)
        LDIOD_WAIT_META: init_state_reg <= LDIOD_WAIT_SYNC;
        LDIOD_WAIT_SYNC: init_state_reg <= LDIOD_LOAD;
        LDIOD_LOAD: begin
          strap_base_reg <= strap_sync_reg ? `LDIOD_CFG_STRAP_HIGH : `LDIOD_CFG_STRAP_LOW;
          init_state_reg <= LDIOD_RUN;
        end
        LDIOD_RUN: init_state_reg <= LDIOD_RUN;
      endcase
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      index_reg <= 8'h00;
      unit_num_reg <= 8'h00;
      osc_reg <= 8'h00;
      cfgb_lo_reg <= 8'h00;
      cfgb_hi_reg <= 8'h00;
      cfg_reloc_reg <= 1'b0;
      unit_on_reg <= 16'h0000;
    end else begin
      unit_on_reg <= unit_on_next;
      if (i_io_wr && cfg_hit_idx) begin
        index_reg <= i_io_wdata;
      end
      if (cfg_wr_data && index_reg == `LDIOD_IDX_UNIT) begin
        unit_num_reg <= i_io_wdata;
      end
      if (cfg_wr_data && index_reg == `LDIOD_IDX_OSC) begin
        osc_reg <= i_io_wdata;
      end
      // RL10 relocation registers
      if (cfg_wr_data && index_reg == `LDIOD_IDX_CFG_LO) begin
        cfgb_lo_reg <= i_io_wdata;
        cfg_reloc_reg <= 1'b1;
      end
      if (cfg_wr_data && index_reg == `LDIOD_IDX_CFG_HI) begin
        cfgb_hi_reg <= i_io_wdata;
        cfg_reloc_reg <= 1'b1;
      end
    end
  end

  // Per-unit base, interrupt and DMA selections
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      for (int i = 0; i < 16; i++) begin
        base_hi_reg[i] <= 8'h00;
        base_lo_reg[i] <= 8'h00;
        // RL4 floppy interrupt default, RL5 DMA defaults
        irq_reg[i] <= (i == 0) ? `LDIOD_IRQ_RST_FDC : `LDIOD_IRQ_RST;
        dma_reg[i] <= (i == 0) ? `LDIOD_DMA_RST_FDC : `LDIOD_DMA_RST;
      end
    end else if (cfg_wr_data) begin
      // RL14 base bytes only where the unit has a base
      if (index_reg == `LDIOD_IDX_BASE_HI && base_ok) begin
        base_hi_reg[cur] <= i_io_wdata;
      end
      if (index_reg == `LDIOD_IDX_BASE_LO && base_ok) begin
        base_lo_reg[cur] <= i_io_wdata;
      end
      if (index_reg == `LDIOD_IDX_IRQ && irq_ok) begin
        irq_reg[cur] <= i_io_wdata[3:0];
      end
      if (index_reg == `LDIOD_IDX_DMA && dma_ok) begin
        dma_reg[cur] <= i_io_wdata[2:0];
      end
    end
  end

  // ----------------------------------------
  // Registered selects and answers
  // ----------------------------------------
  // RL16 select only on a live cycle inside a valid window
  // RL3 an invalid base gives no hit, so the cycle is ignored
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      o_sel_floppy <= 1'b0;
      o_sel_parallel <= 1'b0;
      o_sel_serial1 <= 1'b0;
      o_sel_serial2 <= 1'b0;
      o_sel_keyboard <= 1'b0;
      o_sel_game <= 1'b0;
      o_sel_midi <= 1'b0;
      o_unit_addr <= 16'h0000;
      o_unit_wdata <= 8'h00;
      o_unit_rd <= 1'b0;
      o_unit_wr <= 1'b0;
      o_cfg_rdata <= 8'h00;
      o_cfg_rvalid <= 1'b0;
    end else begin
      o_sel_floppy <= cyc && fdc_hit;
      o_sel_parallel <= cyc && pp_sel;
      o_sel_serial1 <= cyc && sp1_hit;
      o_sel_serial2 <= cyc && sp2_hit;
      o_sel_keyboard <= cyc && (kbd_data_hit || kbd_cmd_hit);
      o_sel_game <= cyc && game_hit;
      o_sel_midi <= cyc && midi_hit;
      o_unit_addr <= i_io_addr;
      o_unit_wdata <= i_io_wdata;
      o_unit_rd <= i_io_rd;
      o_unit_wr <= i_io_wr;
      o_cfg_rvalid <= i_io_rd && (cfg_hit_idx || cfg_hit_data);
      o_cfg_rdata <= cfg_hit_idx ? index_reg : rd_value;
    end
  end

  // RL1 on state is the linked bit
  assign o_unit_on = unit_on_reg;
  assign o_cur_unit = unit_num_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_on_gates_sel: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // RL1
    (o_sel_floppy || o_sel_serial1) |-> ($past(unit_on_reg[0]) || $past(unit_on_reg[4])))
    else $error("select without unit on");
  a_act_pwr_link: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // RL2
    (wr_pwr && cur == 4'h0) |=> (unit_on_reg[0] == $past(i_io_wdata[0])))
    else $error("power write did not reach activate bit");
  a_bad_base_drop: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // RL3
    (cyc && !fdc_valid) |=> !o_sel_floppy)
    else $error("invalid base selected");
  a_fdc_irq_dflt: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // RL4
    $past(!i_resetn) |-> (irq_reg[0] == 4'h6 && irq_reg[3] == 4'h0))
    else $error("interrupt default wrong");
  a_dma_dflt: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // RL5
    $past(!i_resetn) |-> (dma_reg[0] == 3'h2 && dma_reg[3] == 3'h4 && dma_reg[5] == 3'h4))
    else $error("dma default wrong");
  a_serial_window: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // RL6
    o_sel_serial1 |-> ($past(sp1_valid) && $past(i_io_addr[11:3]) == $past(base_sp1[11:3])))
    else $error("serial select outside window");
  a_epp_aligned: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // RL7
    (o_sel_parallel && $past(pp_off) >= 12'h003 && $past(pp_off) <= 12'h007)
    |-> ($past(base_pp[2:0]) == 3'h0 && $past(pp_valid)))
    else $error("enhanced offset on unaligned base");
  a_kbd_fixed: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // RL8
    (cyc && unit_on_reg[7] && i_io_addr == 16'h0064) |=> o_sel_keyboard)
    else $error("keyboard command address missed");
  a_game_single: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // RL9
    o_sel_game |-> ($past(i_io_addr[11:0]) == $past(base_game[11:0])))
    else $error("game select off base");
  a_cfg_index: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // RL10
    (i_io_wr && cfg_hit_idx) |=> (index_reg == $past(i_io_wdata)))
    else $error("index write lost");
  a_addr_qual: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // RL12
    ((o_sel_floppy || o_sel_serial2 || o_sel_keyboard || o_sel_game) && $past(qual16))
    |-> (o_unit_addr[15:12] == 4'h0))
    else $error("upper address not qualified");
  a_strap_port: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // RL13
    (init_state_reg == LDIOD_RUN && $past(init_state_reg) == LDIOD_LOAD)
    |-> (strap_base_reg == ($past(strap_sync_reg) ? 16'h004E : 16'h002E)))
    else $error("strap port position wrong");
endmodule : ldiod_top
`default_nettype wire

/* design/ldiod_params.svh */
// Purpose: Constants for the logical device I/O decoder
// Assumes: Eight-bit configuration data, sixteen-bit host I/O addresses
// Notes: Index values, ranges, reset values and unit masks
//
// Contract
// RL1 - A unit counts as on whenever its activation bit or its power bit is set.
// RL2 - The activation bit and the power bit of a unit are one linked bit.
// RL3 - Host cycles aimed at a unit whose base is out of its legal range are ignored.
// RL4 - After reset the primary interrupt selection of the floppy unit is 0x06.
// RL5 - After reset the DMA selection is 0x02 for unit 0 and 0x04 for units 3 and 5.
// RL6 - Floppy and both serial units decode eight bytes at an 8-aligned base 0x0100-0x0FF8.
// RL7 - Parallel base is 4-aligned up to 0x0FFC, +3..+7 only if 8-aligned, extras at +400h..+402h.
// RL8 - The keyboard unit is fixed at I/O 60 for data and 64 for command and status.
// RL9 - The game unit decodes one register at any byte base 0x0100-0x0FFF.
// RL10 - The config port moves by 0x26/0x27 to a 2-aligned 0x0100-0x0FFE; index at port, data at +1.
// RL11 - The hub unit 0x0C has no I/O range and is never selected.
// RL12 - Bases decode on A11..A0, and on A15..A12 being zero when bit 6 of 0x24 is set; parallel extras at +400h match A15..A12 of base+400h.
// RL13 - At power-up the config port is at 0x02E with the strap low and 0x04E with it high.
// RL14 - Index 0x60 holds base bits 15..8 and 0x61 bits 7..0; unused base registers read zero.
// RL15 - Bit 0 of index 0x30 activates or deactivates the currently chosen unit.
// RL16 - A select needs the unit on, its base valid and aligned, and the address in its window.
// RL17 - Reserved units 0x01, 0x02, 0x06 and 0x08 never produce a select.
`ifndef LDIOD_PARAMS_SVH
`define LDIOD_PARAMS_SVH

// ----------------------------------------
// Configuration indexes
// ----------------------------------------
`define LDIOD_IDX_UNIT 8'h07
`define LDIOD_IDX_PWR 8'h22
`define LDIOD_IDX_OSC 8'h24
`define LDIOD_IDX_CFG_LO 8'h26
`define LDIOD_IDX_CFG_HI 8'h27
`define LDIOD_IDX_ACT 8'h30
`define LDIOD_IDX_BASE_HI 8'h60
`define LDIOD_IDX_BASE_LO 8'h61
`define LDIOD_IDX_IRQ 8'h70
`define LDIOD_IDX_DMA 8'h74
`define LDIOD_OSC_QUAL_BIT 6

// ----------------------------------------
// Config port placement
// ----------------------------------------
`define LDIOD_CFG_STRAP_LOW 16'h002E
`define LDIOD_CFG_STRAP_HIGH 16'h004E
`define LDIOD_CFG_LO 16'h0100
`define LDIOD_CFG_HI 16'h0FFE

// ----------------------------------------
// Unit windows
// ----------------------------------------
`define LDIOD_W8_LO 16'h0100
`define LDIOD_W8_HI 16'h0FF8
`define LDIOD_PP_HI 16'h0FFC
`define LDIOD_GAME_HI 16'h0FFF
`define LDIOD_MIDI_HI 16'h0FFE
`define LDIOD_ECP_OFS 16'h0400
`define LDIOD_KBD_DATA 16'h0060
`define LDIOD_KBD_CMD 16'h0064

// ----------------------------------------
// Unit masks and reset values
// ----------------------------------------
`define LDIOD_ACT_MASK 16'h1AB9
`define LDIOD_BASE_MASK 16'h0A39
`define LDIOD_IRQ_MASK 16'h08B9
`define LDIOD_DMA_MASK 16'h0029
`define LDIOD_IRQ_RST 4'h0
`define LDIOD_IRQ_RST_FDC 4'h6
`define LDIOD_DMA_RST 3'h4
`define LDIOD_DMA_RST_FDC 3'h2

`endif

/* design/ldiod_pkg.sv */
// Purpose: Types of the logical device I/O decoder
// Assumes: Constants come from ldiod_params.svh
// Notes: Types only
`default_nettype none
package ldiod_pkg;
  typedef logic [7:0] ldiod_unit_t;
  typedef enum logic [1:0] {
    LDIOD_WAIT_META,
    LDIOD_WAIT_SYNC,
    LDIOD_LOAD,
    LDIOD_RUN
  } ldiod_init_t;
endpackage : ldiod_pkg
`default_nettype wire

/* design/ldiod_window.sv */
// Purpose: One base-relative decode window
// Assumes: Base and address on the same clock
// Notes: Purely combinational
`timescale 1ns/100ps
`default_nettype none
module ldiod_window #(
  parameter logic [15:0] P_LO = 16'h0100,
  parameter logic [15:0] P_HI = 16'h0FF8,
  parameter logic [15:0] P_ALIGN = 16'h0007,
  parameter logic [15:0] P_WIN = 16'h0007,
  parameter logic [15:0] P_OFS = 16'h0000
) (
  // Programmed state
  input wire logic [15:0] i_base,
  input wire logic i_on,
  input wire logic i_qual16,
  // Host address
  input wire logic [15:0] i_addr,
  // Result
  output logic o_valid,
  output logic o_hit
);
  logic [15:0] target;
  logic match_low;
  logic match_high;

  assign o_valid = (i_base >= P_LO) && (i_base <= P_HI) && ((i_base & P_ALIGN) == 16'h0000);
  assign target = i_base + P_OFS;
  assign match_low = ((i_addr[11:0] & ~P_WIN[11:0]) == (target[11:0] & ~P_WIN[11:0]));
  assign match_high = !i_qual16 || (i_addr[15:12] == target[15:12]);
  assign o_hit = i_on && o_valid && match_low && match_high;
endmodule : ldiod_window
`default_nettype wire

/* verification/ldiod_host.sv */
// Purpose: Host bus controller model issuing I/O cycles
// Assumes: One strobe per cycle, driven just after the rising edge
// Notes: Idle address and data show the inverse of the last value
`timescale 1ns/100ps
`default_nettype none
module ldiod_host (
  // Clock
  input wire logic i_sys_clk,
  // Host I/O cycle
  output logic [15:0] o_io_addr,
  output logic [7:0] o_io_wdata,
  output logic o_io_rd,
  output logic o_io_wr
);
  initial begin
    o_io_addr = 16'h0000;
    o_io_wdata = 8'h00;
    o_io_rd = 1'b0;
    o_io_wr = 1'b0;
  end
  task automatic cyc(input logic wr, input logic [15:0] addr, input logic [7:0] data);
    @(posedge i_sys_clk);
    #1;
    o_io_addr = addr;
    o_io_wdata = data;
    o_io_rd = !wr;
    o_io_wr = wr;
    @(posedge i_sys_clk);
    #1;
    o_io_rd = 1'b0;
    o_io_wr = 1'b0;
    o_io_addr = ~addr;
    o_io_wdata = ~data;
  endtask : cyc
endmodule : ldiod_host
`default_nettype wire

/* verification/test_ldiod_top.sv */
// Purpose: Self-checking bench of the I/O decoder
// Assumes: Strap low at first, high for the second reset
// Notes: Outputs are read one cycle after each strobe
`timescale 1ns/100ps
`default_nettype none
module test_ldiod_top;
  import ldiod_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic strap = 1'b0;
  logic [15:0] port = 16'h002E;
  logic [15:0] addr, uaddr, on;
  logic [7:0] wdata, rdata, uwdata;
  logic rd, wr, rvalid, urd, uwr, s_fl, s_pp, s_s1, s_s2, s_kb, s_gm, s_md;
  ldiod_unit_t cur;
  int checked = 0;
  int mismatches = 0;
  always #10 i_sys_clk = ~i_sys_clk;
  ldiod_host host (.i_sys_clk(i_sys_clk), .o_io_addr(addr), .o_io_wdata(wdata),
    .o_io_rd(rd), .o_io_wr(wr));
  ldiod_top dut (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_config_port_strap(strap),
    .i_io_addr(addr), .i_io_wdata(wdata), .i_io_rd(rd), .i_io_wr(wr),
    .o_cfg_rdata(rdata), .o_cfg_rvalid(rvalid), .o_sel_floppy(s_fl), .o_sel_parallel(s_pp),
    .o_sel_serial1(s_s1), .o_sel_serial2(s_s2), .o_sel_keyboard(s_kb), .o_sel_game(s_gm),
    .o_sel_midi(s_md), .o_unit_addr(uaddr), .o_unit_wdata(uwdata), .o_unit_rd(urd),
    .o_unit_wr(uwr), .o_unit_on(on), .o_cur_unit(cur));
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic cfg_wr(input logic [7:0] idx, input logic [7:0] val);
    host.cyc(1'b1, port, idx);
    host.cyc(1'b1, port + 16'h0001, val);
    check("unit_wdata", {8'h00, val}, {8'h00, uwdata});
    check("unit_wr", 16'h0001, {15'h0000, uwr});
  endtask : cfg_wr
  task automatic cfg_rd(input logic [7:0] idx, input logic [7:0] exp);
    host.cyc(1'b1, port, idx);
    host.cyc(1'b0, port + 16'h0001, 8'h00);
    check("cfg_rvalid", 16'h0001, {15'h0000, rvalid});
    check("cfg_rdata", {8'h00, exp}, {8'h00, rdata});
  endtask : cfg_rd
  task automatic hit(input logic [15:0] a, input logic [6:0] exp);
    host.cyc(1'b0, a, 8'h00);
    check("unit_sel", {9'h000, exp}, {9'h000, s_fl, s_pp, s_s1, s_s2, s_kb, s_gm, s_md});
    check("unit_addr", a, uaddr);
    check("unit_rd", 16'h0001, {15'h0000, urd});
  endtask : hit
  task automatic set_unit(input logic [7:0] u, input logic [15:0] base);
    cfg_wr(8'h07, u);
    check("cur_unit", {8'h00, u}, {8'h00, cur});
    cfg_wr(8'h60, base[15:8]);
    cfg_wr(8'h61, base[7:0]);
    cfg_wr(8'h30, 8'h01);
  endtask : set_unit
  task automatic final_report;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report
  // Guard against a hang
  initial begin
    #200000;
    mismatches++;
    final_report();
  end
  initial begin
    repeat (6) @(posedge i_sys_clk);
    #1;
    i_resetn = 1'b1;
    repeat (5) @(posedge i_sys_clk);
    cfg_wr(8'h07, 8'h00);
    cfg_rd(8'h70, 8'h06);
    cfg_rd(8'h74, 8'h02);
    cfg_wr(8'h07, 8'h03);
    cfg_rd(8'h74, 8'h04);
    cfg_wr(8'h07, 8'h05);
    cfg_rd(8'h74, 8'h04);
    $display("test defaults done");
    set_unit(8'h04, 16'h03F8);
    check("unit_on", 16'h0010, on);
    cfg_rd(8'h22, 8'h10);
    hit(16'h03F8, 7'h10);
    hit(16'h03FF, 7'h10);
    hit(16'h0400, 7'h00);
    hit(16'h13F8, 7'h10);
    cfg_wr(8'h24, 8'h40);
    hit(16'h13F8, 7'h00);
    cfg_wr(8'h24, 8'h00);
    cfg_wr(8'h22, 8'h00);
    check("unit_on", 16'h0000, on);
    hit(16'h03F8, 7'h00);
    $display("test serial done");
    set_unit(8'h05, 16'h00F8);
    hit(16'h00F8, 7'h00);
    set_unit(8'h07, 16'h0000);
    hit(16'h0060, 7'h04);
    hit(16'h0064, 7'h04);
    hit(16'h0061, 7'h00);
    set_unit(8'h09, 16'h0FFF);
    hit(16'h0FFF, 7'h02);
    set_unit(8'h02, 16'h02F8);
    hit(16'h02F8, 7'h00);
    set_unit(8'h03, 16'h0104);
    hit(16'h0106, 7'h20);
    hit(16'h0107, 7'h00);
    hit(16'h0506, 7'h20);
    hit(16'h0507, 7'h00);
    set_unit(8'h03, 16'h0108);
    hit(16'h010B, 7'h20);
    hit(16'h010F, 7'h20);
    set_unit(8'h0B, 16'h0300);
    hit(16'h0301, 7'h01);
    hit(16'h0302, 7'h00);
    set_unit(8'h0C, 16'h0310);
    cfg_rd(8'h60, 8'h00);
    hit(16'h0310, 7'h00);
    $display("test units done");
    cfg_wr(8'h26, 8'h70);
    cfg_wr(8'h27, 8'h03);
    port = 16'h0370;
    cfg_rd(8'h26, 8'h70);
    host.cyc(1'b0, 16'h002F, 8'h00);
    check("cfg_rvalid", 16'h0000, {15'h0000, rvalid});
    strap = 1'b1;
    i_resetn = 1'b0;
    repeat (6) @(posedge i_sys_clk);
    #1;
    i_resetn = 1'b1;
    port = 16'h004E;
    repeat (5) @(posedge i_sys_clk);
    check("unit_on", 16'h0000, on);
    cfg_rd(8'h70, 8'h06);
    $display("test relocate done");
    final_report();
  end
endmodule : test_ldiod_top
`default_nettype wire
